// ==== pkg/lcdcd_defines.svh ====
// constants of the display command decoder
// What this block does and what its host must do
// RULE1 - page origin bit flips page order
// RULE2 - column origin bit flips column order
// RULE3 - write orientation bit picks advance direction
// RULE4 - common scan bit sets scan direction
// RULE5 - colour order bit picks RGB or BGR
// RULE6 - read bottom-up when scan xor invert
// RULE7 - access control bits reset to zero
// RULE8 - 0x37 loads scroll line at next frame
// RULE9 - 0x13 or 0x12 leaves scrolling
// RULE10 - 0x39 idle on, 0x38 idle off
// RULE11 - 0x3A loads three-bit pixel format, reset 011
// RULE12 - eight-bit format routes pixels through lookup
// RULE13 - 0xDE test mode, only no-ops escape
// RULE14 - 0xAA is a second no-op
// RULE15 - 0xC6 initialises internal settings
// RULE16 - DA DB DC B2 are factory tests
// RULE17 - B3 B4 load fifteen gray levels
// RULE18 - host keeps gray levels increasing, in range
// RULE19 - RAM value zero gives fixed output
// RULE20 - host loads banks before sleep exit
// RULE21 - B5 selects bank, 00/11 keep, reset 01
// RULE22 - B6 takes display control bytes in order
// RULE23 - select low is command, high is parameter
// RULE24 - undefined pixel formats are ignored
`ifndef LCDCD_DEFINES_SVH
`define LCDCD_DEFINES_SVH
`define LCDCD_CMD_NOP 8'h00
`define LCDCD_CMD_PARTIAL_ON 8'h12
`define LCDCD_CMD_NORMAL_ON 8'h13
`define LCDCD_CMD_MEM_ACCESS 8'h36
`define LCDCD_CMD_SCROLL_START 8'h37
`define LCDCD_CMD_IDLE_OFF 8'h38
`define LCDCD_CMD_IDLE_ON 8'h39
`define LCDCD_CMD_PIXEL_FORMAT 8'h3A
`define LCDCD_CMD_SECOND_NO_OPERATION_CMD 8'hAA
`define LCDCD_CMD_FACT_B2 8'hB2
`define LCDCD_CMD_GRAY0_LOAD 8'hB3
`define LCDCD_CMD_GRAY1_LOAD 8'hB4
`define LCDCD_CMD_GRAY_SELECT 8'hB5
`define LCDCD_CMD_DISPLAY_CTL 8'hB6
`define LCDCD_CMD_INIT_ESCAPE 8'hC6
`define LCDCD_CMD_FACT_DA 8'hDA
`define LCDCD_CMD_FACT_DB 8'hDB
`define LCDCD_CMD_FACT_DC 8'hDC
`define LCDCD_CMD_TEST_ENTRY 8'hDE
`define LCDCD_BIT_PAGE_ORIGIN 7
`define LCDCD_BIT_COLUMN_ORIGIN 6
`define LCDCD_BIT_WRITE_ORIENT 5
`define LCDCD_BIT_COMMON_SCAN 4
`define LCDCD_BIT_COLOUR_ORDER 3
`define LCDCD_BIT_VERT_INVERT 0
`define LCDCD_FMT_8BPP 3'h2
`define LCDCD_FMT_12BPP 3'h3
`define LCDCD_GSEL_BANK0 2'h1
`define LCDCD_GSEL_BANK1 2'h2
`define LCDCD_GRAY_ENTRIES 4'hF
`define LCDCD_GRAY_ZERO_LEVEL 8'h00
`define LCDCD_SCROLL_RESET 8'h00
`define LCDCD_IDX_MAX 4'hF
`endif

// ==== pkg/lcdcd_pkg.sv ====
// types shared by the display command decoder
package lcdcd_pkg;
   typedef logic [7:0] lcdcd_byte_t;
   typedef logic [2:0] lcdcd_fmt_t;
   typedef enum logic [8:0] {
      LCDCD_ST_IDLE = 9'h001,
      LCDCD_ST_MEMORY_ACCESS_CONTROL_CMD = 9'h002,
      LCDCD_ST_SCROLL = 9'h004,
      LCDCD_ST_PIXFMT = 9'h008,
      LCDCD_ST_GRAY0 = 9'h010,
      LCDCD_ST_GRAY1 = 9'h020,
      LCDCD_ST_GSEL = 9'h040,
      LCDCD_ST_DISPLAY_CONTROL_CMD = 9'h080,
      LCDCD_ST_TEST = 9'h100
   } lcdcd_state_e;
endpackage

// ==== core/lcdcd_gray_mem.sv ====
// two banks of gray level entries with registered read
`timescale 1ns/1ps
`include "lcdcd_defines.svh"
module lcdcd_gray_mem #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic wr_en,
   input wire logic wr_bank,
   input wire logic [3:0] wr_idx,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic rd_bank,
   input wire logic [3:0] rd_idx,
   output logic [WIDTH-1:0] rd_data_q
);
   // contents are undefined after reset, so no reset here
   logic [WIDTH-1:0] mem [0:31];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[{wr_bank, wr_idx}] <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rd_idx == 4'h0) begin
         rd_data_q <= WIDTH'(`LCDCD_GRAY_ZERO_LEVEL); // RULE19
      end else begin
         rd_data_q <= mem[{rd_bank, rd_idx}];
      end
   end
endmodule // lcdcd_gray_mem

// ==== core/lcdcd_core.sv ====
// command and parameter decoder of the colour display driver
`timescale 1ns/1ps
`include "lcdcd_defines.svh"
module lcdcd_core (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic BYTE_VALID,
   input wire logic BYTE_DC,
   input wire lcdcd_pkg::lcdcd_byte_t BYTE_DATA,
   input wire logic FRAME_START,
   input wire logic [3:0] GRAY_RD_INDEX,
   output logic PAGE_ORIGIN,
   output logic COLUMN_ORIGIN,
   output logic WRITE_ORIENTATION,
   output logic COMMON_SCAN,
   output logic COLOUR_ORDER,
   output logic VERTICAL_INVERT,
   output logic RAM_READ_BOTTOM_UP,
   output lcdcd_pkg::lcdcd_byte_t SCROLL_START_LINE,
   output logic SCROLL_ACTIVE,
   output logic IDLE_MODE,
   output lcdcd_pkg::lcdcd_fmt_t PIXEL_FORMAT,
   output logic LUT_TRANSLATE,
   output logic TEST_MODE,
   output logic INIT_ESCAPE,
   output logic FACTORY_TEST,
   output logic GRAY_BANK_SEL,
   output lcdcd_pkg::lcdcd_byte_t GRAY_LEVEL,
   output logic DISPLAY_CTL_WR,
   output logic [3:0] DISPLAY_CTL_INDEX,
   output lcdcd_pkg::lcdcd_byte_t DISPLAY_CTL_BYTE
);
   import lcdcd_pkg::*;

   // =========================================
   // byte classification
   lcdcd_state_e state_q;
   lcdcd_state_e state_d;
   logic [3:0] idx_q;
   logic is_cmd;
   logic is_par;
   logic [7:0] memory_access_control_cmd_q;
   logic [7:0] scroll_pend_q;
   logic [7:0] scroll_line_q;
   logic scroll_act_q;
   logic idle_q;
   logic [2:0] fmt_q;
   logic gsel_q;
   logic init_q;
   logic fact_q;
   logic dwr_q;
   logic [3:0] didx_q;
   logic [7:0] dbyte_q;
   logic gray_wr;

   assign is_cmd = BYTE_VALID && !BYTE_DC; // RULE23
   assign is_par = BYTE_VALID && BYTE_DC; // RULE23

   function automatic logic is_noop(input logic [7:0] c);
      is_noop = (c == `LCDCD_CMD_NOP) || (c == `LCDCD_CMD_SECOND_NO_OPERATION_CMD); // RULE13 RULE14
   endfunction

   function automatic logic fmt_defined(input logic [2:0] f);
      fmt_defined = (f == `LCDCD_FMT_8BPP) || (f == `LCDCD_FMT_12BPP);
   endfunction

   // =========================================
   // command state
   always_comb begin
      state_d = state_q;
      if (state_q == LCDCD_ST_TEST) begin
         if (is_cmd && is_noop(BYTE_DATA)) begin
            state_d = LCDCD_ST_IDLE; // RULE13
         end
      end else if (is_cmd) begin
         case (BYTE_DATA)
            `LCDCD_CMD_MEM_ACCESS: begin
               state_d = LCDCD_ST_MEMORY_ACCESS_CONTROL_CMD;
            end
            `LCDCD_CMD_SCROLL_START: begin
               state_d = LCDCD_ST_SCROLL;
            end
            `LCDCD_CMD_PIXEL_FORMAT: begin
               state_d = LCDCD_ST_PIXFMT;
            end
            `LCDCD_CMD_GRAY0_LOAD: begin
               state_d = LCDCD_ST_GRAY0;
            end
            `LCDCD_CMD_GRAY1_LOAD: begin
               state_d = LCDCD_ST_GRAY1;
            end
            `LCDCD_CMD_GRAY_SELECT: begin
               state_d = LCDCD_ST_GSEL;
            end
            `LCDCD_CMD_DISPLAY_CTL: begin
               state_d = LCDCD_ST_DISPLAY_CONTROL_CMD;
            end
            `LCDCD_CMD_TEST_ENTRY: begin
               state_d = LCDCD_ST_TEST; // RULE13
            end
            // the second no-op lands here: it only ends the running sequence
            default: begin
               state_d = LCDCD_ST_IDLE; // RULE23 RULE14
            end
         endcase
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         state_q <= LCDCD_ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // parameter position within the current command, saturating
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         idx_q <= 4'h0;
      end else if (is_cmd) begin
         idx_q <= 4'h0; // RULE23
      end else if (is_par && idx_q != `LCDCD_IDX_MAX) begin
         idx_q <= idx_q + 4'h1;
      end
   end

   // =========================================
   // memory access control
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         memory_access_control_cmd_q <= 8'h00; // RULE7
      end else if (is_par && state_q == LCDCD_ST_MEMORY_ACCESS_CONTROL_CMD && idx_q == 4'h0) begin
         memory_access_control_cmd_q <= BYTE_DATA;
      end
   end

   assign PAGE_ORIGIN = memory_access_control_cmd_q[`LCDCD_BIT_PAGE_ORIGIN]; // RULE1
   assign COLUMN_ORIGIN = memory_access_control_cmd_q[`LCDCD_BIT_COLUMN_ORIGIN]; // RULE2
   assign WRITE_ORIENTATION = memory_access_control_cmd_q[`LCDCD_BIT_WRITE_ORIENT]; // RULE3
   assign COMMON_SCAN = memory_access_control_cmd_q[`LCDCD_BIT_COMMON_SCAN]; // RULE4
   assign COLOUR_ORDER = memory_access_control_cmd_q[`LCDCD_BIT_COLOUR_ORDER]; // RULE5
   assign VERTICAL_INVERT = memory_access_control_cmd_q[`LCDCD_BIT_VERT_INVERT]; // RULE6
   // read order follows the combination of scan and invert
   assign RAM_READ_BOTTOM_UP = memory_access_control_cmd_q[`LCDCD_BIT_COMMON_SCAN] ^ memory_access_control_cmd_q[`LCDCD_BIT_VERT_INVERT]; // RULE6

   // =========================================
   // vertical scroll
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         scroll_pend_q <= `LCDCD_SCROLL_RESET;
      end else if (is_par && state_q == LCDCD_ST_SCROLL && idx_q == 4'h0) begin
         scroll_pend_q <= BYTE_DATA; // RULE8
      end
   end

   // the shown line changes only at a frame edge to avoid a torn picture
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         scroll_line_q <= `LCDCD_SCROLL_RESET;
      end else if (FRAME_START) begin
         scroll_line_q <= scroll_pend_q; // RULE8
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         scroll_act_q <= 1'b0;
      end else if (state_q != LCDCD_ST_TEST && is_cmd &&
                   (BYTE_DATA == `LCDCD_CMD_NORMAL_ON || BYTE_DATA == `LCDCD_CMD_PARTIAL_ON)) begin
         scroll_act_q <= 1'b0; // RULE9
      end else if (is_par && state_q == LCDCD_ST_SCROLL && idx_q == 4'h0) begin
         scroll_act_q <= 1'b1;
      end
   end

   assign SCROLL_START_LINE = scroll_line_q;
   assign SCROLL_ACTIVE = scroll_act_q;

   // =========================================
   // idle mode and pixel format
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         idle_q <= 1'b0; // RULE10
      end else if (state_q != LCDCD_ST_TEST && is_cmd) begin
         if (BYTE_DATA == `LCDCD_CMD_IDLE_ON) begin
            idle_q <= 1'b1; // RULE10
         end else if (BYTE_DATA == `LCDCD_CMD_IDLE_OFF) begin
            idle_q <= 1'b0; // RULE10
         end
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         fmt_q <= `LCDCD_FMT_12BPP; // RULE11
      end else if (is_par && state_q == LCDCD_ST_PIXFMT && idx_q == 4'h0 && fmt_defined(BYTE_DATA[2:0])) begin
         fmt_q <= BYTE_DATA[2:0]; // RULE11 RULE24
      end
   end

   assign IDLE_MODE = idle_q;
   assign PIXEL_FORMAT = fmt_q;
   assign LUT_TRANSLATE = (fmt_q == `LCDCD_FMT_8BPP); // RULE12
   assign TEST_MODE = (state_q == LCDCD_ST_TEST);

   // =========================================
   // one-cycle command strobes
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         init_q <= 1'b0;
         fact_q <= 1'b0;
      end else begin
         init_q <= state_q != LCDCD_ST_TEST && is_cmd && BYTE_DATA == `LCDCD_CMD_INIT_ESCAPE; // RULE15
         fact_q <= state_q != LCDCD_ST_TEST && is_cmd &&
                   (BYTE_DATA == `LCDCD_CMD_FACT_DA || BYTE_DATA == `LCDCD_CMD_FACT_DB ||
                    BYTE_DATA == `LCDCD_CMD_FACT_DC || BYTE_DATA == `LCDCD_CMD_FACT_B2); // RULE16
      end
   end

   assign INIT_ESCAPE = init_q;
   assign FACTORY_TEST = fact_q;

   // =========================================
   // gray level banks
   assign gray_wr = is_par && (state_q == LCDCD_ST_GRAY0 || state_q == LCDCD_ST_GRAY1) &&
                    idx_q < `LCDCD_GRAY_ENTRIES; // RULE17

   lcdcd_gray_mem #(
      .WIDTH(8)
   ) u_gray_mem (
      .clk(MCLK),
      .wr_en(gray_wr),
      .wr_bank(state_q == LCDCD_ST_GRAY1),
      .wr_idx(idx_q + 4'h1),
      .wr_data(BYTE_DATA),
      .rd_bank(gsel_q),
      .rd_idx(GRAY_RD_INDEX),
      .rd_data_q(GRAY_LEVEL)
   ); // RULE17 RULE19

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         gsel_q <= 1'b0; // RULE21
      end else if (is_par && state_q == LCDCD_ST_GSEL && idx_q == 4'h0) begin
         if (BYTE_DATA[1:0] == `LCDCD_GSEL_BANK0) begin
            gsel_q <= 1'b0; // RULE21
         end else if (BYTE_DATA[1:0] == `LCDCD_GSEL_BANK1) begin
            gsel_q <= 1'b1; // RULE21
         end
      end
   end

   assign GRAY_BANK_SEL = gsel_q;

   // =========================================
   // display control bytes, handed on with their position
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         dwr_q <= 1'b0;
         didx_q <= 4'h0;
         dbyte_q <= 8'h00;
      end else begin
         dwr_q <= is_par && state_q == LCDCD_ST_DISPLAY_CONTROL_CMD; // RULE22
         if (is_par && state_q == LCDCD_ST_DISPLAY_CONTROL_CMD) begin
            didx_q <= idx_q; // RULE22
            dbyte_q <= BYTE_DATA;
         end
      end
   end

   assign DISPLAY_CTL_WR = dwr_q;
   assign DISPLAY_CTL_INDEX = didx_q;
   assign DISPLAY_CTL_BYTE = dbyte_q;

   // =========================================
   // checks
   // judged against the parameter byte itself, not against the outputs it feeds
   property p_read_order;
      @(posedge MCLK) disable iff (RST)
      (is_par && state_q == LCDCD_ST_MEMORY_ACCESS_CONTROL_CMD && idx_q == 4'h0) |=>
         RAM_READ_BOTTOM_UP == ($past(BYTE_DATA[4]) ^ $past(BYTE_DATA[0]));
   endproperty
   a_read_order: assert property (p_read_order) else $error("read order mismatch"); // RULE6

   property p_memory_access_control_cmd_load;
      @(posedge MCLK) disable iff (RST)
      (is_par && state_q == LCDCD_ST_MEMORY_ACCESS_CONTROL_CMD && idx_q == 4'h0) |=> PAGE_ORIGIN == $past(BYTE_DATA[7]) &&
         COLOUR_ORDER == $past(BYTE_DATA[3]);
   endproperty
   a_memory_access_control_cmd_load: assert property (p_memory_access_control_cmd_load) else $error("access control not loaded"); // RULE1

   property p_scroll_frame;
      @(posedge MCLK) disable iff (RST)
      !FRAME_START |=> $stable(SCROLL_START_LINE);
   endproperty
   a_scroll_frame: assert property (p_scroll_frame) else $error("scroll line moved mid frame"); // RULE8

   property p_scroll_exit;
      @(posedge MCLK) disable iff (RST)
      (is_cmd && !TEST_MODE && BYTE_DATA == `LCDCD_CMD_NORMAL_ON) |=> !SCROLL_ACTIVE;
   endproperty
   a_scroll_exit: assert property (p_scroll_exit) else $error("scroll not left"); // RULE9

   property p_idle_on;
      @(posedge MCLK) disable iff (RST)
      (is_cmd && !TEST_MODE && BYTE_DATA == `LCDCD_CMD_IDLE_ON) |=> IDLE_MODE;
   endproperty
   a_idle_on: assert property (p_idle_on) else $error("idle not entered"); // RULE10

   property p_fmt_defined;
      @(posedge MCLK) disable iff (RST)
      PIXEL_FORMAT == `LCDCD_FMT_8BPP || PIXEL_FORMAT == `LCDCD_FMT_12BPP;
   endproperty
   a_fmt_defined: assert property (p_fmt_defined) else $error("undefined pixel format held"); // RULE24

   property p_test_hold;
      @(posedge MCLK) disable iff (RST)
      (TEST_MODE && !(is_cmd && is_noop(BYTE_DATA))) |=> TEST_MODE && $stable(IDLE_MODE) && $stable(memory_access_control_cmd_q);
   endproperty
   a_test_hold: assert property (p_test_hold) else $error("test mode left or state changed"); // RULE13

   property p_second_no_operation_cmd;
      @(posedge MCLK) disable iff (RST)
      (is_cmd && !TEST_MODE && BYTE_DATA == `LCDCD_CMD_SECOND_NO_OPERATION_CMD) |=> $stable(memory_access_control_cmd_q) && $stable(IDLE_MODE) &&
         $stable(PIXEL_FORMAT) && $stable(GRAY_BANK_SEL);
   endproperty
   a_second_no_operation_cmd: assert property (p_second_no_operation_cmd) else $error("second no-op changed state"); // RULE14

   property p_gsel_keep;
      @(posedge MCLK) disable iff (RST)
      (is_par && state_q == LCDCD_ST_GSEL && (BYTE_DATA[1:0] == 2'h0 || BYTE_DATA[1:0] == 2'h3))
         |=> $stable(GRAY_BANK_SEL);
   endproperty
   a_gsel_keep: assert property (p_gsel_keep) else $error("bank choice not kept"); // RULE21

   property p_zero_level;
      @(posedge MCLK) disable iff (RST)
      (GRAY_RD_INDEX == 4'h0) |=> GRAY_LEVEL == `LCDCD_GRAY_ZERO_LEVEL;
   endproperty
   a_zero_level: assert property (p_zero_level) else $error("zero entry not fixed"); // RULE19

   c_test_escape: cover property (@(posedge MCLK) disable iff (RST) TEST_MODE ##1 !TEST_MODE);
   c_gray_last: cover property (@(posedge MCLK) disable iff (RST) gray_wr && idx_q == 4'hE);
   c_lut: cover property (@(posedge MCLK) disable iff (RST) $rose(LUT_TRANSLATE));
   c_display_control_cmd: cover property (@(posedge MCLK) disable iff (RST) DISPLAY_CTL_WR && DISPLAY_CTL_INDEX == 4'h5);
endmodule // lcdcd_core

// ==== verification/lcdcd_host_model.sv ====
// host processor model that sends command and parameter bytes
`timescale 1ns/1ps
module lcdcd_host_model (
   input wire logic mclk,
   output logic byte_valid,
   output logic byte_dc,
   output lcdcd_pkg::lcdcd_byte_t byte_data
);
   import lcdcd_pkg::*;
   initial begin
      byte_valid = 1'b0;
      byte_dc = 1'b0;
      byte_data = 8'h00;
   end
   // ==========================================
   // byte transfers
   // valid stays high between sends so bytes may run back to back
   task automatic send(input logic dc, input lcdcd_byte_t data);
      @(negedge mclk);
      byte_valid = 1'b1;
      byte_dc = dc;
      byte_data = data;
   endtask
   // a released data line shows the inverse of the last byte, so stale data never looks valid
   task automatic quiet();
      @(negedge mclk);
      byte_valid = 1'b0;
      byte_data = ~byte_data;
   endtask
   // ==========================================
   // setup sequences
   // init escape goes first, before any bank load or display start
   task automatic setup();
      send(1'b0, 8'hC6);
      quiet();
   endtask
   // levels strictly rise with the entry and stay at 2 or above; banks are loaded before display start
   task automatic load_gray(input lcdcd_byte_t code, input lcdcd_byte_t base, input lcdcd_byte_t step);
      send(1'b0, code);
      for (int i = 1; i <= 15; i++) begin
         send(1'b1, lcdcd_byte_t'(base + step * i));
      end
      quiet();
   endtask
endmodule // lcdcd_host_model

// ==== verification/lcdcd_core_tb.sv ====
// self-checking bench of the display command decoder
`timescale 1ns/1ps
module lcdcd_core_tb;
   import lcdcd_pkg::*;
   logic mclk, rst, byte_valid, byte_dc, frame_start;
   lcdcd_byte_t byte_data, scroll_line, gray_level, dctl_byte;
   logic [3:0] gray_idx, dctl_idx;
   logic po, co, wo, cs, clo, vi, rbu, scroll_act, idle, lut, test, init_esc, fact, bank_sel, dctl_wr;
   lcdcd_fmt_t fmt;
   int n_fail = 0;
   int total_checks = 0;
   int n_init = 0;
   int n_fact = 0;
   int n_dctl = 0;
   lcdcd_host_model host (.mclk(mclk), .byte_valid(byte_valid), .byte_dc(byte_dc), .byte_data(byte_data));
   lcdcd_core DUT (.MCLK(mclk), .RST(rst), .BYTE_VALID(byte_valid), .BYTE_DC(byte_dc), .BYTE_DATA(byte_data),
      .FRAME_START(frame_start), .GRAY_RD_INDEX(gray_idx), .PAGE_ORIGIN(po), .COLUMN_ORIGIN(co),
      .WRITE_ORIENTATION(wo), .COMMON_SCAN(cs), .COLOUR_ORDER(clo), .VERTICAL_INVERT(vi),
      .RAM_READ_BOTTOM_UP(rbu), .SCROLL_START_LINE(scroll_line), .SCROLL_ACTIVE(scroll_act),
      .IDLE_MODE(idle), .PIXEL_FORMAT(fmt), .LUT_TRANSLATE(lut), .TEST_MODE(test),
      .INIT_ESCAPE(init_esc), .FACTORY_TEST(fact), .GRAY_BANK_SEL(bank_sel), .GRAY_LEVEL(gray_level),
      .DISPLAY_CTL_WR(dctl_wr), .DISPLAY_CTL_INDEX(dctl_idx), .DISPLAY_CTL_BYTE(dctl_byte));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // pulses are counted by cycle, so their exact landing cycle does not matter
   always @(posedge mclk) begin
      if (init_esc === 1'b1) n_init++;
      if (fact === 1'b1) n_fact++;
      if (dctl_wr === 1'b1) n_dctl++;
   end
   // ==========================================
   // common tasks
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic settle();
      repeat (2) @(negedge mclk);
   endtask
   task automatic c1(input lcdcd_byte_t code);
      host.send(1'b0, code);
      host.quiet();
      settle();
   endtask
   task automatic p1(input lcdcd_byte_t code, input lcdcd_byte_t prm);
      host.send(1'b0, code);
      host.send(1'b1, prm);
      host.quiet();
      settle();
   endtask
   // ==========================================
   // scenarios
   task automatic t_reset();
      check("access", {po, co, wo, cs, clo, 2'b00, vi}, 8'h00);
      check("scroll_line", scroll_line, 8'h00);
      check("idle", 8'(idle), 8'h00);
      check("format", 8'(fmt), 8'h03);
      check("bank", 8'(bank_sel), 8'h00);
      check("test", 8'(test), 8'h00);
   endtask
   task automatic t_strobes();
      int n;
      n = n_fact;
      host.setup();
      settle();
      check("init_pulses", 8'(n_init), 8'h01);
      host.send(1'b0, 8'hDA);
      host.send(1'b0, 8'hDB);
      host.send(1'b0, 8'hDC);
      host.send(1'b0, 8'hB2);
      host.quiet();
      settle();
      check("fact_pulses", 8'(n_fact - n), 8'h04);
   endtask
   task automatic t_access();
      lcdcd_byte_t tbl [4] = '{8'h11, 8'hF9, 8'h10, 8'h01};
      foreach (tbl[i]) begin
         host.send(1'b0, 8'h36);
         host.send(1'b1, tbl[i]);
         // one byte beyond the count must be dropped
         host.send(1'b1, ~tbl[i]);
         host.quiet();
         settle();
         check("access", {po, co, wo, cs, clo, 2'b00, vi}, tbl[i] & 8'hF9);
         check("bottom_up", 8'(rbu), 8'(tbl[i][4] ^ tbl[i][0]));
      end
      host.send(1'b0, 8'h36);
      host.send(1'b0, 8'hAA);
      host.send(1'b1, 8'hFF);
      host.quiet();
      settle();
      check("access", {po, co, wo, cs, clo, 2'b00, vi}, 8'h01);
   endtask
   task automatic t_scroll();
      p1(8'h37, 8'h05);
      check("scroll_act", 8'(scroll_act), 8'h01);
      check("scroll_line", scroll_line, 8'h00);
      @(negedge mclk);
      frame_start = 1'b1;
      @(negedge mclk);
      frame_start = 1'b0;
      settle();
      check("scroll_line", scroll_line, 8'h05);
      c1(8'h13);
      check("scroll_act", 8'(scroll_act), 8'h00);
      p1(8'h37, 8'h2A);
      check("scroll_act", 8'(scroll_act), 8'h01);
      c1(8'h12);
      check("scroll_act", 8'(scroll_act), 8'h00);
   endtask
   task automatic t_idle();
      c1(8'h39);
      check("idle", 8'(idle), 8'h01);
      c1(8'hAA);
      check("idle", 8'(idle), 8'h01);
      c1(8'h38);
      check("idle", 8'(idle), 8'h00);
   endtask
   task automatic t_format();
      lcdcd_byte_t bad [6] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06, 8'h07};
      p1(8'h3A, 8'hFA);
      check("format", 8'(fmt), 8'h02);
      check("lut", 8'(lut), 8'h01);
      foreach (bad[i]) begin
         p1(8'h3A, bad[i]);
         check("format", 8'(fmt), 8'h02);
      end
      p1(8'h3A, 8'h03);
      check("format", 8'(fmt), 8'h03);
      check("lut", 8'(lut), 8'h00);
   endtask
   task automatic t_test();
      int n;
      n = n_init;
      c1(8'hDE);
      check("test", 8'(test), 8'h01);
      c1(8'h39);
      c1(8'hC6);
      check("idle", 8'(idle), 8'h00);
      check("init_pulses", 8'(n_init - n), 8'h00);
      check("test", 8'(test), 8'h01);
      c1(8'h00);
      check("test", 8'(test), 8'h00);
      c1(8'hDE);
      c1(8'hAA);
      check("test", 8'(test), 8'h00);
   endtask
   task automatic t_gray_bank(input logic [7:0] base, input logic [7:0] step);
      for (int i = 0; i < 16; i++) begin
         @(negedge mclk);
         gray_idx = 4'(i);
         settle();
         check("gray", gray_level, (i == 0) ? 8'h00 : 8'(base + step * i));
      end
   endtask
   task automatic t_gray();
      host.load_gray(8'hB3, 8'h00, 8'h0A);
      host.load_gray(8'hB4, 8'h01, 8'h05);
      settle();
      p1(8'hB5, 8'h01);
      t_gray_bank(8'h00, 8'h0A);
      p1(8'hB5, 8'h02);
      check("bank", 8'(bank_sel), 8'h01);
      t_gray_bank(8'h01, 8'h05);
      p1(8'hB5, 8'h00);
      p1(8'hB5, 8'hFF);
      check("bank", 8'(bank_sel), 8'h01);
      p1(8'hB5, 8'h01);
      check("bank", 8'(bank_sel), 8'h00);
   endtask
   task automatic t_display_control_cmd();
      int n;
      n = n_dctl;
      host.send(1'b0, 8'hB6);
      for (int k = 0; k < 7; k++) begin
         host.send(1'b1, lcdcd_byte_t'(8'h10 + k));
      end
      host.quiet();
      settle();
      check("dctl_pulses", 8'(n_dctl - n), 8'h07);
      check("dctl_index", 8'(dctl_idx), 8'h06);
      check("dctl_byte", dctl_byte, 8'h16);
   endtask
   // ==========================================
   // main sequence
   initial begin
      rst = 1'b1;
      frame_start = 1'b0;
      gray_idx = 4'h0;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      t_reset();
      t_strobes();
      t_access();
      t_scroll();
      t_idle();
      t_format();
      t_test();
      t_gray();
      t_display_control_cmd();
      end_of_test();
   end
   // the tests need well under a thousand cycles; ten thousand means a hang
   initial begin
      #1000000;
      n_fail++;
      end_of_test();
   end
endmodule // lcdcd_core_tb
